/* pkg/rmp_pkg.sv */
// Constants, field layouts and carrier types for the ramp modulator.
// Assumes a single phase-detector clock and an AXI4-Lite register master.
package rmp_pkg;
  localparam int RMP_AW = 8;
  localparam int RMP_DW = 32;
  localparam int RMP_FRAC_W = 25;
  localparam int RMP_INT_W = 12;
  localparam int RMP_DIV_W = RMP_INT_W + RMP_FRAC_W;
  localparam int RMP_NUM_CFG = 7;
  // Register byte offsets
  localparam logic [RMP_AW-1:0] RMP_OFS_INT_FRAC = 8'h00;
  localparam logic [RMP_AW-1:0] RMP_OFS_FRAC_LO = 8'h04;
  localparam logic [RMP_AW-1:0] RMP_OFS_RDIV = 8'h08;
  localparam logic [RMP_AW-1:0] RMP_OFS_FUNC = 8'h0C;
  localparam logic [RMP_AW-1:0] RMP_OFS_CLOCK = 8'h10;
  localparam logic [RMP_AW-1:0] RMP_OFS_DEVIATION = 8'h14;
  localparam logic [RMP_AW-1:0] RMP_OFS_STEP = 8'h18;
  localparam logic [RMP_AW-1:0] RMP_OFS_STAT_FRAC = 8'h1C;
  localparam logic [RMP_AW-1:0] RMP_OFS_STAT_INT = 8'h20;
  localparam logic [RMP_DW-1:0] RMP_CFG_RESET = 32'h0000_0000;
  // Field positions
  localparam int RMP_START_BIT = 31;
  localparam int RMP_INT_MSB = 26, RMP_INT_LSB = 15;
  localparam int RMP_FHI_MSB = 14, RMP_FHI_LSB = 3;
  localparam int RMP_FLO_MSB = 27, RMP_FLO_LSB = 15;
  localparam int RMP_PH_MSB = 14, RMP_PH_LSB = 3;
  localparam int RMP_HTDA_MSB = 14, RMP_HTDA_LSB = 3;
  localparam int RMP_HTDB_MSB = 18, RMP_HTDB_LSB = 7;
  localparam int RMP_CMODE_MSB = 20, RMP_CMODE_LSB = 19;
  localparam int RMP_DVW_MSB = 18, RMP_DVW_LSB = 3;
  localparam int RMP_SHF_MSB = 22, RMP_SHF_LSB = 19;
  localparam int RMP_STEP_MSB = 22, RMP_STEP_LSB = 3;
  localparam int RMP_SHAPE_MSB = 11, RMP_SHAPE_LSB = 10;
  localparam int RMP_MOD_MSB = 9, RMP_MOD_LSB = 8;
  localparam int RMP_STRI_BIT = 13;
  localparam int RMP_SI_BUSY = 31;
  localparam int RMP_SI_PH_LSB = 16;
  localparam logic [1:0] RMP_CMODE_RAMP = 2'h3;
  localparam logic [1:0] RMP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RMP_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {RMP_MOD_NONE, RMP_MOD_FSK, RMP_MOD_PSK, RMP_MOD_RSVD} rmp_mod_t;
  typedef enum logic [1:0] {RMP_SH_CONT_SAW, RMP_SH_TRI, RMP_SH_SINGLE_SAW, RMP_SH_SINGLE_RAMP} rmp_shape_t;
  typedef struct packed {
    logic [RMP_INT_W-1:0] int_part;
    logic [RMP_FRAC_W-1:0] frac_part;
    logic [11:0] phase_off;
    logic ramp_active;
  } rmp_synth_t;
endpackage

/* rtl/rmp_modulator.sv */
// FSK/PSK modulation and sweep generator for the divider word.
// Assumes aclk is the phase-detector clock and tx_data is asynchronous.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module rmp_modulator import rmp_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [RMP_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [RMP_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RMP_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [RMP_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_data,
  output rmp_synth_t synth_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_UP, ST_DOWN, ST_WRAP, ST_HOLD} rmp_state_t;

  logic [RMP_DW-1:0] cfg_q [RMP_NUM_CFG];
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [RMP_AW-1:0] awaddr_q;
  logic [RMP_DW-1:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write, start_pulse, run, hop, leg_done, timer_on;
  logic [3:0] widx, ridx;
  logic [RMP_DW-1:0] rd_word, wr_word;
  logic [2:0] tx_sync_q;
  logic tx_q;
  rmp_state_t state_q;
  logic [19:0] cnt_q;
  logic [23:0] timer_q, period, period_m1;
  logic [RMP_DIV_W-1:0] acc_q, base, dstep;
  logic [11:0] phase_q, ph_val;
  logic [15:0] deviation_word;
  logic [3:0] shift_w;
  logic [19:0] step_w;
  rmp_shape_t shape;
  rmp_mod_t mod_sel;
  logic single_tri;

  // Map a byte address to a config index, or the invalid index
  function automatic logic [3:0] cfg_index(input logic [RMP_AW-1:0] a);
    logic [3:0] i;
    i = 4'hF;
    if (a == RMP_OFS_INT_FRAC) begin
      i = 4'h0;
    end else if (a == RMP_OFS_FRAC_LO) begin
      i = 4'h1;
    end else if (a == RMP_OFS_RDIV) begin
      i = 4'h2;
    end else if (a == RMP_OFS_FUNC) begin
      i = 4'h3;
    end else if (a == RMP_OFS_CLOCK) begin
      i = 4'h4;
    end else if (a == RMP_OFS_DEVIATION) begin
      i = 4'h5;
    end else if (a == RMP_OFS_STEP) begin
      i = 4'h6;
    end
    return i;
  endfunction

  // Byte-lane merge of write data over an old word
  function automatic logic [RMP_DW-1:0] merge(input logic [RMP_DW-1:0] old, input logic [RMP_DW-1:0] nw,
                                              input logic [3:0] strb);
    logic [RMP_DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Divider word from the integer/fraction word and the fraction-low word
  function automatic logic [RMP_DIV_W-1:0] div_word(input logic [RMP_DW-1:0] w0, input logic [RMP_DW-1:0] w1);
    return {w0[RMP_INT_MSB:RMP_INT_LSB], w0[RMP_FHI_MSB:RMP_FHI_LSB], w1[RMP_FLO_MSB:RMP_FLO_LSB]};
  endfunction

  // Handshake outputs
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write happens once address and data are both held
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign widx = cfg_index(awaddr_q);
  assign ridx = cfg_index(s_axi_araddr);
  assign wr_word = merge(cfg_q[3'(widx)], wdata_q, wstrb_q);
  assign start_pulse = do_write && (widx == 4'h0) && wr_word[RMP_START_BIT];

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RMP_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (widx < 4'(RMP_NUM_CFG)) ? RMP_RESP_OKAY : RMP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Configuration words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < RMP_NUM_CFG; i++) begin
        cfg_q[i] <= RMP_CFG_RESET;
      end
    end else if (do_write && widx < 4'(RMP_NUM_CFG)) begin
      cfg_q[3'(widx)] <= wr_word;
    end
  end

  // Read decode
  always_comb begin
    rd_word = '0;
    if (ridx < 4'(RMP_NUM_CFG)) begin
      rd_word = cfg_q[3'(ridx)];
    end else if (s_axi_araddr == RMP_OFS_STAT_FRAC) begin
      rd_word[RMP_FRAC_W-1:0] = acc_q[RMP_FRAC_W-1:0];
    end else if (s_axi_araddr == RMP_OFS_STAT_INT) begin
      rd_word[RMP_INT_W-1:0] = acc_q[RMP_DIV_W-1:RMP_FRAC_W];
      rd_word[RMP_SI_PH_LSB +: 12] = phase_q;
      rd_word[RMP_SI_BUSY] = synth_o.ramp_active;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RMP_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (ridx < 4'(RMP_NUM_CFG) || s_axi_araddr == RMP_OFS_STAT_FRAC ||
                  s_axi_araddr == RMP_OFS_STAT_INT) ? RMP_RESP_OKAY : RMP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Field extraction
  assign base = div_word(cfg_q[0], cfg_q[1]);
  assign deviation_word = cfg_q[5][RMP_DVW_MSB:RMP_DVW_LSB];
  assign shift_w = cfg_q[5][RMP_SHF_MSB:RMP_SHF_LSB];
  assign dstep = RMP_DIV_W'($signed(deviation_word)) << shift_w;
  assign ph_val = cfg_q[1][RMP_PH_MSB:RMP_PH_LSB];
  assign step_w = cfg_q[6][RMP_STEP_MSB:RMP_STEP_LSB];
  assign shape = rmp_shape_t'(cfg_q[3][RMP_SHAPE_MSB:RMP_SHAPE_LSB]);
  assign mod_sel = rmp_mod_t'(cfg_q[3][RMP_MOD_MSB:RMP_MOD_LSB]);
  assign single_tri = cfg_q[3][RMP_STRI_BIT];
  assign run = cfg_q[0][RMP_START_BIT];

  // Modulation pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sync_q <= '0;
      tx_q <= 1'b0;
    end else begin
      tx_sync_q <= {tx_sync_q[1:0], tx_data};
      if (tx_sync_q[1] == tx_sync_q[2]) begin
        tx_q <= tx_sync_q[2];
      end
    end
  end

  // Hop timer, period is the product of both dividers
  assign period = 24'(cfg_q[2][RMP_HTDA_MSB:RMP_HTDA_LSB] * cfg_q[4][RMP_HTDB_MSB:RMP_HTDB_LSB]);
  assign period_m1 = (period == 24'h00_0000) ? 24'h00_0000 : period - 24'h00_0001;
  assign timer_on = (state_q == ST_UP || state_q == ST_DOWN || state_q == ST_WRAP) &&
                    cfg_q[4][RMP_CMODE_MSB:RMP_CMODE_LSB] == RMP_CMODE_RAMP;
  assign hop = timer_on && !start_pulse && timer_q == period_m1;
  assign leg_done = (cnt_q + 20'h0_0001) >= step_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_q <= '0;
    end else if (!timer_on || start_pulse || hop) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_q + 24'h00_0001;
    end
  end

  // Sweep sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else if (start_pulse) begin
      state_q <= ST_UP;
      cnt_q <= '0;
    end else if (!run) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else if (hop) begin
      case (state_q)
        ST_UP: begin
          if (leg_done) begin
            cnt_q <= '0;
            case (shape)
              RMP_SH_SINGLE_RAMP: state_q <= ST_HOLD;
              RMP_SH_TRI: state_q <= ST_DOWN;
              default: state_q <= ST_WRAP;
            endcase
          end else begin
            cnt_q <= cnt_q + 20'h0_0001;
          end
        end
        ST_DOWN: begin
          if (leg_done) begin
            cnt_q <= '0;
            state_q <= single_tri ? ST_HOLD : ST_UP;
          end else begin
            cnt_q <= cnt_q + 20'h0_0001;
          end
        end
        ST_WRAP: state_q <= (shape == RMP_SH_CONT_SAW) ? ST_UP : ST_HOLD;
        default: state_q <= state_q;
      endcase
    end
  end

  // Divider accumulator, one step per hop while sweeping, reloaded every cycle when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= '0;
    end else if (start_pulse) begin
      acc_q <= div_word(wr_word, cfg_q[1]);
    end else if (state_q == ST_IDLE || !run) begin
      if (mod_sel == RMP_MOD_FSK) begin
        acc_q <= tx_q ? base + dstep : base - dstep;
      end else begin
        acc_q <= base;
      end
    end else if (hop) begin
      case (state_q)
        ST_UP: acc_q <= acc_q + dstep;
        ST_DOWN: acc_q <= acc_q - dstep;
        ST_WRAP: acc_q <= base;
        default: acc_q <= acc_q;
      endcase
    end
  end

  // Phase offset for PSK
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= '0;
    end else if (mod_sel == RMP_MOD_PSK) begin
      phase_q <= tx_q ? ph_val : 12'h000 - ph_val;
    end else begin
      phase_q <= '0;
    end
  end

  // Output bundle, one driver for the whole struct
  assign synth_o = '{int_part: acc_q[RMP_DIV_W-1:RMP_FRAC_W], frac_part: acc_q[RMP_FRAC_W-1:0],
                     phase_off: phase_q, ramp_active: (state_q != ST_IDLE) && (state_q != ST_HOLD)};

endmodule

/* testbench/rmp_tx_src.sv */
// Modulation data source driving the asynchronous tx_data pin.
// Assumes the bench sets the wanted level; the pin follows off the clock grid.
`timescale 1ns/1ps
module rmp_tx_src (
  input wire logic level,
  output logic tx_data
);
  // Pin lags the request by a delay unrelated to aclk, unknown until 7 ns after time zero
  assign #7 tx_data = level;
endmodule

/* testbench/rmp_modulator_props.sv */
// Bus handshake and sweep assertions for the ramp modulator.
// Assumes it is bound onto rmp_modulator and sees only its ports.
`timescale 1ns/1ps
module rmp_modulator_props import rmp_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [RMP_DW-1:0] s_axi_rdata,
  input rmp_synth_t synth_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Divider and phase cleared when reset lifts
  AST_RESET_CLEAR: assert property ($rose(aresetn) |-> synth_o == '0)
    else $error("outputs not cleared by reset");
  // A sweep only starts with a register write
  AST_START_BY_WRITE: assert property ($rose(synth_o.ramp_active) |-> $rose(s_axi_bvalid))
    else $error("sweep started without a write");
  AST_B_AFTER_HS: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write response without both handshakes");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_B_CLEAR: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_AR_TO_R: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_NO_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
endmodule
bind rmp_modulator rmp_modulator_props chk_u (.*);

/* testbench/testbench.sv */
// Register-driven test of sweeps, FSK and PSK of the ramp modulator.
// Assumes hop timer 2x3 cycles, 3 steps of one integer unit, base integer 5.
`timescale 1ns/1ps
module testbench import rmp_pkg::*;;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_data, tx_level;
  logic [RMP_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [RMP_DW-1:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  rmp_synth_t synth_o;
  int n_mismatch, checked, n, hi;
  logic [11:0] v;
  logic [31:0] fn [5] = '{32'h0000_0C00, 32'h0000_0800, 32'h0000_2400, 32'h0000_0400, 32'h0};
  logic ea [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [11:0] ei [5] = '{12'h008, 12'h005, 12'h005, 12'h005, 12'h005};
  rmp_modulator dut_u (.*);
  rmp_tx_src src_u (.level(tx_level), .tx_data(tx_data));
  // Clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b1;
      end
    end while (!(ad && wd));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd_v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    give_verdict;
  end
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_level} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RMP_OFS_DEVIATION);
    chk(rd_v, RMP_CFG_RESET);
    rd(8'h40);
    chk(resp, RMP_RESP_SLVERR);
    wr(RMP_OFS_STAT_FRAC, 32'h0000_0001);
    chk(resp, RMP_RESP_SLVERR);
    wr(RMP_OFS_STEP, 32'h0000_0018);
    wr(RMP_OFS_DEVIATION, 32'h005A_0000);
    rd(RMP_OFS_DEVIATION);
    chk(rd_v, 32'h005A_0000);
    wr(RMP_OFS_CLOCK, 32'h0018_0180);
    wr(RMP_OFS_RDIV, 32'h0000_0010);
    // Top byte lane only, divider field untouched
    s_axi_wstrb <= 4'h8;
    wr(RMP_OFS_RDIV, 32'hFF00_0000);
    s_axi_wstrb <= 4'hF;
    rd(RMP_OFS_RDIV);
    chk(rd_v, 32'hFF00_0010);
    // Every sweep shape from base 5, three hops of one unit
    for (int i = 0; i < 5; i++) begin
      wr(RMP_OFS_FUNC, fn[i]);
      wr(RMP_OFS_INT_FRAC, 32'h8002_8000);
      for (int k = 0; k < 2; k++) begin
        v = synth_o.int_part;
        n = 0;
        while (synth_o.int_part === v && n < 50) begin
          @(posedge aclk);
          n++;
        end
      end
      chk(n, 6);
      hi = 0;
      repeat (120) begin
        @(posedge aclk);
        if (synth_o.int_part > hi) hi = synth_o.int_part;
      end
      chk(hi, 8);
      rd(RMP_OFS_STAT_INT);
      chk(rd_v[31], ea[i]);
      if (!ea[i]) chk(synth_o.int_part, ei[i]);
      wr(RMP_OFS_INT_FRAC, 32'h0002_8000);
      chk(synth_o.ramp_active, 1'b0);
    end
    // FSK about the base, one integer unit either side
    wr(RMP_OFS_FUNC, 32'h0000_0100);
    for (int k = 1; k >= 0; k--) begin
      tx_level <= k[0];
      repeat (8) @(posedge aclk);
      chk(synth_o.int_part, k ? 12'h006 : 12'h004);
    end
    // PSK with a quarter-turn phase value
    wr(RMP_OFS_FRAC_LO, 32'h0000_2000);
    wr(RMP_OFS_FUNC, 32'h0000_0200);
    for (int k = 1; k >= 0; k--) begin
      tx_level <= k[0];
      repeat (8) @(posedge aclk);
      chk(synth_o.phase_off, k ? 12'h400 : 12'hC00);
    end
    rd(RMP_OFS_STAT_INT);
    chk(rd_v[27:16], 12'hC00);
    give_verdict;
  end
endmodule
